// [common/msc_link_if.sv]
// sideband pins and serial bus between host board and module
`timescale 1ns/1ns
interface msc_link_if;
  logic module_select_n;
  logic module_reset_n;
  logic init_control_select;
  logic init_control_oe_n;
  logic module_present_n;
  logic present_pull_oe_n;
  logic interrupt_out_n;
  logic int_drive_oe_n;
  logic scl;
  logic scl_host_oe_n;
  logic sda;
  logic sda_host_oe_n;
  logic sda_dev_oe_n;
  logic init_host_level;

  // wire resolution: pull-ups on host, pulls are open drain
  assign module_present_n    = present_pull_oe_n;
  assign interrupt_out_n     = int_drive_oe_n;
  assign scl                 = scl_host_oe_n;
  assign sda                 = sda_host_oe_n & sda_dev_oe_n;
  assign init_control_select = init_control_oe_n ? 1'b1 : init_host_level;

  modport device (
    input  module_select_n, module_reset_n, init_control_select, scl, sda,
    output present_pull_oe_n, int_drive_oe_n, sda_dev_oe_n
  );
  modport host (
    input  module_present_n, interrupt_out_n, sda,
    output module_select_n, module_reset_n, init_control_oe_n, init_host_level,
           scl_host_oe_n, sda_host_oe_n
  );
endinterface : msc_link_if

// [common/msc_pkg.sv]
// shared constants and types for the module sideband control block
//
// Notes on behaviour
// - serial commands answered only while selected low
// - host gives each module its own select
// - long enough reset low restores all defaults
// - host ignores status until reset completes
// - completion shown by interrupt with not-ready cleared
// - completion interrupt also raised after power-up
// - undriven init control reads high, software mode
// - software mode stays low power until enabled
// - hardware mode goes high power after init
// - host holds init control fixed while present
// - fitted module grounds the presence line
// - interrupt pulled low for fault or status
// - host reads memory to find interrupt source
// - interrupt open drain, host supplies pull-up
// - memory map read and written over serial bus
package msc_pkg;

  // minimum reset low time, taken as 10 us at 20 MHz
  localparam int unsigned MSC_RESET_MIN_NS  = 10000;
  localparam int unsigned MSC_CLK_PERIOD_NS = 50;
  localparam int unsigned MSC_RESET_MIN_CYC =
    (MSC_RESET_MIN_NS + MSC_CLK_PERIOD_NS - 1) / MSC_CLK_PERIOD_NS;
  // management interface initialisation time after reset
  localparam int unsigned MSC_INIT_CYC      = 16;
  // serial clock half period used by the host bit engine
  localparam int unsigned MSC_SCL_HALF_CYC  = 8;

  localparam int unsigned MSC_ADDR_W = 8;
  localparam int unsigned MSC_DATA_W = 8;
  localparam logic [6:0]  MSC_DEV_ADDR = 7'h50;

  // memory map locations
  localparam logic [7:0] MSC_ADR_STATUS = 8'h02;
  localparam logic [7:0] MSC_ADR_FLAGS  = 8'h03;
  localparam logic [7:0] MSC_ADR_CTRL   = 8'h1a;
  localparam int unsigned MSC_BIT_NOT_READY = 0;
  localparam int unsigned MSC_BIT_HIGH_PWR  = 1;
  localparam int unsigned MSC_BIT_FLT_RESET = 0;
  localparam int unsigned MSC_BIT_FLT_FAULT = 1;
  localparam int unsigned MSC_BIT_PWR_EN    = 0;
  localparam logic [7:0] MSC_MEM_RESET  = 8'h00;

endpackage : msc_pkg

// [logic/msc_device.sv]
// module end: select gating, reset filter, power mode, interrupt, serial slave
`timescale 1ns/1ns
module msc_device
  import msc_pkg::*;
#(
  parameter int unsigned RESET_MIN_CYC = MSC_RESET_MIN_CYC,
  parameter int unsigned INIT_CYC      = MSC_INIT_CYC
) (
  input  wire logic  mclk_i,
  input  wire logic  rst_i,
  msc_link_if.device link,
  input  wire logic  fault_i,
  output logic       high_power_o,
  output logic       reset_done_o
);

  initial begin
    if (RESET_MIN_CYC < 1 || RESET_MIN_CYC > 65535) $error("bad RESET_MIN_CYC");
    if (INIT_CYC < 1 || INIT_CYC > 65535) $error("bad INIT_CYC");
  end

  typedef enum logic [2:0] {
    MSC_S_IDLE = 3'b000,
    MSC_S_ADDR = 3'b001,
    MSC_S_AACK = 3'b010,
    MSC_S_WR   = 3'b011,
    MSC_S_WACK = 3'b100,
    MSC_S_RD   = 3'b101,
    MSC_S_RACK = 3'b110
  } msc_sl_e;

  typedef struct packed {
    logic [15:0] rst_cnt;
    logic [15:0] init_cnt;
    logic        initing;
    logic        not_ready;
    logic [1:0]  flags;
    logic        pwr_en;
    logic        high_pwr;
    logic        scl_q;
    logic        sda_q;
    msc_sl_e     st;
    logic [3:0]  bitn;
    logic [7:0]  shreg;
    logic        rw;
    logic        have_ptr;
    logic [7:0]  ptr;
    logic        sda_oe_n;
    logic        int_oe_n;
    logic        done;
  } msc_dev_s;

  msc_dev_s q, d;
  logic scl_rise, scl_fall, start_c, stop_c, sel;
  logic [7:0] rd_byte;

  assign scl_rise = link.scl & ~q.scl_q;
  assign scl_fall = ~link.scl & q.scl_q;
  assign start_c  = link.scl & q.scl_q & q.sda_q & ~link.sda;
  assign stop_c   = link.scl & q.scl_q & ~q.sda_q & link.sda;
  assign sel      = ~link.module_select_n;

  always_comb
  begin
    case (q.ptr)
      MSC_ADR_STATUS: rd_byte = {6'h00, q.high_pwr, q.not_ready};
      MSC_ADR_FLAGS:  rd_byte = {6'h00, q.flags};
      MSC_ADR_CTRL:   rd_byte = {7'h00, q.pwr_en};
      default:        rd_byte = MSC_MEM_RESET;
    endcase
  end

  always_comb
  begin
    d = q;
    d.scl_q = link.scl;
    d.sda_q = link.sda;
    d.done  = 1'b0;
    // hardware vs software power-up; pin must be held, read live
    if (!q.not_ready)
    begin
      if (link.init_control_select)
        d.high_pwr = q.pwr_en;
      else
        d.high_pwr = 1'b1;
    end
    if (q.initing)
    begin
      if (q.init_cnt == 16'(INIT_CYC - 1))
      begin
        d.initing   = 1'b0;
        d.not_ready = 1'b0;
        d.done      = 1'b1;
      end
      else
        d.init_cnt = q.init_cnt + 16'h0001;
    end
    // serial slave, only while selected
    if (!sel || stop_c)
    begin
      d.st = MSC_S_IDLE;
      d.sda_oe_n = 1'b1;
    end
    else if (start_c)
    begin
      d.st = MSC_S_ADDR;
      d.bitn = 4'h0;
      d.have_ptr = 1'b0;
      d.sda_oe_n = 1'b1;
    end
    else
    begin
      case (q.st)
        MSC_S_IDLE: d.sda_oe_n = 1'b1;
        MSC_S_ADDR, MSC_S_WR:
          if (scl_rise)
          begin
            d.shreg = {q.shreg[6:0], link.sda};
            d.bitn  = q.bitn + 4'h1;
          end
          else if (scl_fall && q.bitn == 4'h8)
          begin
            d.bitn = 4'h0;
            if (q.st == MSC_S_ADDR)
            begin
              if (q.shreg[7:1] == MSC_DEV_ADDR)
              begin
                d.rw = q.shreg[0];
                d.st = MSC_S_AACK;
                d.sda_oe_n = 1'b0;
              end
              else
                d.st = MSC_S_IDLE;
            end
            else
            begin
              d.st = MSC_S_WACK;
              d.sda_oe_n = 1'b0;
              if (!q.have_ptr)
              begin
                d.ptr = q.shreg;
                d.have_ptr = 1'b1;
              end
              else
              begin
                if (q.ptr == MSC_ADR_CTRL) d.pwr_en = q.shreg[MSC_BIT_PWR_EN];
                if (q.ptr == MSC_ADR_FLAGS) d.flags = q.flags & ~q.shreg[1:0];
                d.ptr = q.ptr + 8'h01;
              end
            end
          end
        MSC_S_AACK, MSC_S_WACK:
          if (scl_fall)
          begin
            if (q.st == MSC_S_AACK && q.rw)
            begin
              d.st = MSC_S_RD;
              d.shreg = rd_byte;
              d.sda_oe_n = rd_byte[7];
              d.bitn = 4'h1;
              // clear-on-read of flags; new events same cycle still set
              if (q.ptr == MSC_ADR_FLAGS) d.flags = '0;
            end
            else
            begin
              d.st = MSC_S_WR;
              d.sda_oe_n = 1'b1;
            end
          end
        MSC_S_RD:
          if (scl_fall)
          begin
            if (q.bitn == 4'h8)
            begin
              d.st = MSC_S_RACK;
              d.sda_oe_n = 1'b1;
              d.ptr = q.ptr + 8'h01;
            end
            else
            begin
              d.shreg = {q.shreg[6:0], 1'b0};
              d.sda_oe_n = q.shreg[6];
              d.bitn = q.bitn + 4'h1;
            end
          end
        MSC_S_RACK:
          if (scl_rise)
            d.st = link.sda ? MSC_S_IDLE : MSC_S_AACK;
        default: d.st = MSC_S_IDLE;
      endcase
    end
    // events are applied after the read and write clears so those never hide them; a qualified reset still wipes them
    if (fault_i) d.flags[MSC_BIT_FLT_FAULT] = 1'b1;
    if (q.initing && q.init_cnt == 16'(INIT_CYC - 1))
      d.flags[MSC_BIT_FLT_RESET] = 1'b1;
    // only ever pull low or release
    d.int_oe_n = ~(|d.flags);
    // qualified long reset low restarts everything
    if (!link.module_reset_n)
    begin
      if (q.rst_cnt != 16'(RESET_MIN_CYC))
        d.rst_cnt = q.rst_cnt + 16'h0001;
      else
      begin
        d = '0;
        d.rst_cnt   = q.rst_cnt;
        d.not_ready = 1'b1;
        d.sda_oe_n  = 1'b1;
        d.int_oe_n  = 1'b1;
        d.scl_q     = link.scl;
        d.sda_q     = link.sda;
      end
    end
    else if (q.rst_cnt == 16'(RESET_MIN_CYC))
    begin
      d.rst_cnt = '0;
      d.initing = 1'b1;
    end
    else
      d.rst_cnt = '0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.not_ready <= 1'b1;
      q.initing   <= 1'b1;
      q.sda_oe_n  <= 1'b1;
      q.int_oe_n  <= 1'b1;
      q.scl_q     <= 1'b1;
      q.sda_q     <= 1'b1;
    end
    else
      q <= d;
  end

  assign link.present_pull_oe_n = 1'b0;
  assign link.int_drive_oe_n    = q.int_oe_n;
  assign link.sda_dev_oe_n      = q.sda_oe_n;
  assign high_power_o           = q.high_pwr;
  assign reset_done_o           = q.done;
  // pull-up of init control is resolved in the interface

endmodule // msc_device

// [logic/msc_host.sv]
// host end: select, reset pulse, init level, single byte serial access
`timescale 1ns/1ns
module msc_host
  import msc_pkg::*;
#(
  parameter int unsigned RESET_MIN_CYC = MSC_RESET_MIN_CYC
) (
  input  wire logic  mclk_i,
  input  wire logic  rst_i,
  msc_link_if.host   link,
  input  wire logic  hw_init_i,
  input  wire logic  reset_req_i,
  input  wire logic  req_i,
  input  wire logic  req_wr_i,
  input  wire logic [7:0] req_addr_i,
  input  wire logic [7:0] req_wdata_i,
  output logic       busy_o,
  output logic       ack_o,
  output logic       nak_o,
  output logic [7:0] rdata_o,
  output logic       present_o,
  output logic       int_o
);

  initial if (RESET_MIN_CYC < 1 || RESET_MIN_CYC > 65534) $error("bad RESET_MIN_CYC");

  typedef enum logic [1:0] {
    MSC_H_IDLE = 2'b00,
    MSC_H_RST  = 2'b01,
    MSC_H_XFER = 2'b10
  } msc_hst_e;

  typedef struct packed {
    msc_hst_e    st;
    logic [15:0] cnt;
    logic        rstn;
    logic        seln;
    logic        scl;
    logic        sda;
    logic [5:0]  step;
    logic [3:0]  ph;
    logic [35:0] tx;
    logic        wr;
    logic [7:0]  rx;
    logic        nak;
    logic        ack;
    logic        waitrst;
    logic        pres;
    logic        intr;
    logic        busy;
  } msc_host_s;

  // bit slots of one frame, counted in serial clock periods from the start
  localparam logic [5:0] STP_ADDR_ACK  = 6'd8;
  localparam logic [5:0] STP_PTR_ACK   = 6'd17;
  localparam logic [5:0] STP_RSTART    = 6'd18;
  localparam logic [5:0] STP_WDATA_ACK = 6'd26;
  localparam logic [5:0] STP_RADDR_ACK = 6'd27;
  localparam logic [5:0] STP_RD_FIRST  = 6'd28;
  localparam logic [5:0] STP_RD_LAST   = 6'd35;
  localparam logic [5:0] STP_WR_END    = 6'd30;
  localparam logic [5:0] STP_RD_END    = 6'd41;

  msc_host_s q, d;
  logic [5:0] last;

  assign last = q.wr ? STP_WR_END : STP_RD_END;

  always_comb
  begin
    d = q;
    d.ack  = 1'b0;
    d.pres = ~link.module_present_n;
    // interrupt shown only once reset completed
    d.intr = ~link.interrupt_out_n & ~q.waitrst;
    // a stale interrupt seen while the pulse is still out must not end the wait
    if (q.waitrst && q.st != MSC_H_RST && !link.interrupt_out_n) d.waitrst = 1'b0;
    case (q.st)
      MSC_H_IDLE:
        if (reset_req_i)
        begin
          d.st = MSC_H_RST;
          d.cnt = '0;
          d.rstn = 1'b0;
          d.waitrst = 1'b1;
        end
        else if (req_i)
        begin
          d.st = MSC_H_XFER;
          d.seln = 1'b0;
          d.wr = req_wr_i;
          // frame: addr+w, ptr, (data | rstart addr+r, read)
          d.tx = {MSC_DEV_ADDR, 1'b0, 1'b1, req_addr_i, 1'b1,
                  req_wr_i ? req_wdata_i : {MSC_DEV_ADDR, 1'b1}, 1'b1, 9'h1ff};
          d.step = '0;
          d.ph = '0;
          d.nak = 1'b0;
          d.sda = 1'b0;
        end
      MSC_H_RST:
        // hold low two cycles past the minimum
        if (q.cnt == 16'(RESET_MIN_CYC + 1))
        begin
          d.rstn = 1'b1;
          d.st = MSC_H_IDLE;
        end
        else
          d.cnt = q.cnt + 16'h0001;
      MSC_H_XFER:
        if (q.ph != 4'(MSC_SCL_HALF_CYC - 1))
        begin
          d.ph = q.ph + 4'h1;
          // repeated start: data must fall while the clock stands high
          if (!q.wr && q.scl && q.step == STP_RSTART + 6'd1 &&
              q.ph == 4'(MSC_SCL_HALF_CYC / 2))
            d.sda = 1'b0;
        end
        else
        begin
          d.ph = '0;
          d.scl = ~q.scl;
          if (q.scl)
          begin
            // falling edge: present next bit or finish
            if (q.step == last)
            begin
              d.sda = 1'b0;
            end
            else if (!q.wr && q.step == STP_RSTART)
              d.sda = 1'b1;
            else
            begin
              d.sda = q.tx[35];
              d.tx = {q.tx[34:0], 1'b1};
            end
          end
          else
          begin
            if (q.step == last + 6'd1)
            begin
              d.scl = 1'b1;
              d.sda = 1'b1;
              d.seln = 1'b1;
              d.st = MSC_H_IDLE;
              d.ack = 1'b1;
            end
            else
            begin
              if (q.step == STP_ADDR_ACK || q.step == STP_PTR_ACK ||
                  (q.wr ? q.step == STP_WDATA_ACK : q.step == STP_RADDR_ACK))
                d.nak = q.nak | link.sda;
              if (!q.wr && q.step >= STP_RD_FIRST && q.step <= STP_RD_LAST)
                d.rx = {q.rx[6:0], link.sda};
              d.step = q.step + 6'd1;
            end
          end
        end
      default: d.st = MSC_H_IDLE;
    endcase
    d.busy = (d.st != MSC_H_IDLE);
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.rstn <= 1'b1;
      q.seln <= 1'b1;
      q.scl  <= 1'b1;
      q.sda  <= 1'b1;
      q.waitrst <= 1'b1;
    end
    else
      q <= d;
  end

  assign link.module_reset_n    = q.rstn;
  assign link.module_select_n   = q.seln;
  assign link.scl_host_oe_n     = q.scl;
  assign link.sda_host_oe_n     = q.sda;
  assign link.init_host_level   = 1'b0;
  assign link.init_control_oe_n = ~hw_init_i;
  assign busy_o    = q.busy;
  assign ack_o     = q.ack;
  assign nak_o     = q.nak;
  assign rdata_o   = q.rx;
  assign present_o = q.pres;
  assign int_o     = q.intr;

endmodule // msc_host

// [verification/msc_link_monitor.sv]
// concurrent checks on the sideband link between the host and module ends
`timescale 1ns/1ns
module msc_link_monitor
  import msc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic init_control_select,
  input wire logic init_control_oe_n,
  input wire logic present_pull_oe_n,
  input wire logic int_drive_oe_n,
  input wire logic scl,
  input wire logic sda_dev_oe_n
);
  // covers reset filter plus init time, with margin for pin registers
  localparam int SETTLE_LIM = 40;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  // pin held low past the filter length, then let go
  sequence long_reset_s;
    !module_reset_n [*8] ##1 module_reset_n;
  endsequence

  sequence int_posted_s;
    ##[1:SETTLE_LIM] !int_drive_oe_n;
  endsequence

  sel_gate_a: assert property (module_select_n [*2] |-> sda_dev_oe_n)
    else $error("module drove data while deselected");
  sel_frame_a: assert property (!scl |-> !module_select_n)
    else $error("serial clock low without module select");
  boot_int_a: assert property ($fell(rst_i) |-> int_posted_s)
    else $error("no completion interrupt after power-up");
  reset_post_a: assert property (long_reset_s |-> int_posted_s)
    else $error("no completion interrupt after reset pulse");
  reset_quiet_a: assert property (long_reset_s |-> int_drive_oe_n)
    else $error("interrupt still pulled after reset pulse");
  present_gnd_a: assert property (!$past(rst_i) |-> !present_pull_oe_n)
    else $error("presence line not grounded");
  sda_hold_a: assert property (scl && $past(scl) |-> $stable(sda_dev_oe_n))
    else $error("module changed data while clock high");
  init_fixed_a: assert property (
    !$past(rst_i) && !$past(rst_i, 2) |-> $stable(init_control_oe_n))
    else $error("init control changed in operation");
  init_pullup_a: assert property (init_control_oe_n |-> init_control_select)
    else $error("released init control not read high");
endmodule // msc_link_monitor

// [verification/tb_module_sideband_control.sv]
// self-checking bench for the sideband host and module ends
`timescale 1ns/1ns
module tb_module_sideband_control;
  import msc_pkg::*;
  logic       mclk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       fault = 1'b0;
  logic       hw_init = 1'b0;
  logic       reset_req = 1'b0;
  logic       req = 1'b0;
  logic       req_wr = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_wdata = 8'h00;
  logic       high_power;
  logic       reset_done;
  logic       busy;
  logic       ack;
  logic       nak;
  logic [7:0] rdata;
  logic       present;
  logic       int_lvl;
  int         error_cnt = 0;
  int         samples_checked = 0;
  int         done_cnt = 0;

  msc_link_if lnk ();
  // short device filter, longer host pulse so the filter always qualifies
  msc_device #(.RESET_MIN_CYC(4), .INIT_CYC(MSC_INIT_CYC)) i_msc_device (
    .mclk_i       (mclk_i),
    .rst_i        (rst_i),
    .link         (lnk.device),
    .fault_i      (fault),
    .high_power_o (high_power),
    .reset_done_o (reset_done)
  );
  msc_host #(.RESET_MIN_CYC(8)) i_msc_host (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .link        (lnk.host),
    .hw_init_i   (hw_init),
    .reset_req_i (reset_req),
    .req_i       (req),
    .req_wr_i    (req_wr),
    .req_addr_i  (req_addr),
    .req_wdata_i (req_wdata),
    .busy_o      (busy),
    .ack_o       (ack),
    .nak_o       (nak),
    .rdata_o     (rdata),
    .present_o   (present),
    .int_o       (int_lvl)
  );
  msc_link_monitor i_msc_link_monitor (
    .mclk_i              (mclk_i),
    .rst_i               (rst_i),
    .module_select_n     (lnk.module_select_n),
    .module_reset_n      (lnk.module_reset_n),
    .init_control_select (lnk.init_control_select),
    .init_control_oe_n   (lnk.init_control_oe_n),
    .present_pull_oe_n   (lnk.present_pull_oe_n),
    .int_drive_oe_n      (lnk.int_drive_oe_n),
    .scl                 (lnk.scl),
    .sda_dev_oe_n        (lnk.sda_dev_oe_n)
  );

  always #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (reset_done === 1'b1) done_cnt++;

  task automatic tick();
    @(posedge mclk_i);
    #5;
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_pin(input logic lvl);
    for (int n = 0; n < 200 && lnk.interrupt_out_n !== lvl; n++)
      tick();
    tick();
    tick();
  endtask

  task automatic wait_hp(input logic lvl);
    for (int n = 0; n < 200 && high_power !== lvl; n++)
      tick();
  endtask

  // one whole frame per request; the next waits for busy to drop
  task automatic xfer(input logic wr, input logic [7:0] adr, input logic [7:0] wd);
    for (int n = 0; n < 100 && busy !== 1'b0; n++)
      tick();
    req_wr = wr;
    req_addr = adr;
    req_wdata = wd;
    req = 1'b1;
    tick();
    req = 1'b0;
    for (int n = 0; n < 2000 && ack !== 1'b1; n++)
      tick();
    chk1("ack", 1'b1, ack);
    chk1("nak", 1'b0, nak);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
    xfer(1'b0, adr, 8'h00);
    chk8("rdata", exp, rdata);
  endtask

  task automatic pulse_fault();
    fault = 1'b1;
    tick();
    fault = 1'b0;
    wait_pin(1'b0);
  endtask

  task automatic t_boot();
    chk1("init_pin", 1'b1, lnk.init_control_select);
    wait_pin(1'b0);
    chk1("int_pin", 1'b0, lnk.interrupt_out_n);
    chk1("int_o", 1'b1, int_lvl);
    chk1("done_pulse", 1'b1, done_cnt == 1);
    chk1("present_pin", 1'b0, lnk.module_present_n);
    chk1("present_o", 1'b1, present);
  endtask

  task automatic t_flags();
    rd(MSC_ADR_STATUS, 8'h00);
    rd(MSC_ADR_FLAGS, 8'h01);
    wait_pin(1'b1);
    chk1("int_pin", 1'b1, lnk.interrupt_out_n);
    rd(MSC_ADR_FLAGS, 8'h00);
  endtask

  task automatic t_power();
    chk1("high_power", 1'b0, high_power);
    xfer(1'b1, MSC_ADR_CTRL, 8'h01);
    wait_hp(1'b1);
    chk1("high_power", 1'b1, high_power);
    rd(MSC_ADR_STATUS, 8'h02);
    rd(MSC_ADR_CTRL, 8'h01);
  endtask

  task automatic t_fault();
    pulse_fault();
    chk1("int_pin", 1'b0, lnk.interrupt_out_n);
    rd(MSC_ADR_FLAGS, 8'h02);
    wait_pin(1'b1);
    chk1("int_pin", 1'b1, lnk.interrupt_out_n);
  endtask

  // fault left pending so the reset has a flag to wipe
  task automatic t_modreset();
    int n;
    int m;
    n = 0;
    m = 0;
    pulse_fault();
    reset_req = 1'b1;
    tick();
    reset_req = 1'b0;
    for (int k = 0; k < 100; k++)
    begin
      if (lnk.module_reset_n === 1'b0)
        n++;
      if (n > 1 && lnk.module_reset_n === 1'b0 && int_lvl === 1'b1)
        m++;
      tick();
    end
    chk1("reset_len", 1'b1, n >= 8);
    chk1("int_hidden", 1'b1, m == 0);
    chk1("high_power", 1'b0, high_power);
    wait_pin(1'b0);
    chk1("int_pin", 1'b0, lnk.interrupt_out_n);
    chk1("done_pulse", 1'b1, done_cnt == 2);
    chk1("int_o", 1'b1, int_lvl);
    rd(MSC_ADR_CTRL, 8'h00);
    rd(MSC_ADR_STATUS, 8'h00);
    rd(MSC_ADR_FLAGS, 8'h01);
  endtask

  // init level only changes while both ends are held in reset
  task automatic t_hwmode();
    rst_i = 1'b1;
    hw_init = 1'b1;
    repeat (4) tick();
    rst_i = 1'b0;
    tick();
    tick();
    chk1("init_pin", 1'b0, lnk.init_control_select);
    wait_hp(1'b1);
    chk1("high_power", 1'b1, high_power);
    wait_pin(1'b0);
    chk1("int_pin", 1'b0, lnk.interrupt_out_n);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (16) tick();
    rst_i = 1'b0;
    t_boot();
    t_flags();
    t_power();
    t_fault();
    t_modreset();
    t_hwmode();
    conclude();
  end

  initial
  begin
    repeat (40000) @(posedge mclk_i);
    error_cnt++;
    conclude();
  end
endmodule // tb_module_sideband_control
